// *** pkg/gpio_port_consts.svh ***
// register indices, reset values and widths of the seven-pin port
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH
`define GP_PIN_COUNT 7
`define GP_ADDR_W 18
`define GP_IDX_DIR 16'hFE32
`define GP_IDX_ODR 16'hFE46
`define GP_IDX_IPSEL 16'hFE4A
`define GP_IDX_LATCH 16'hFF02
`define GP_IDX_VIEW 16'hFFB2
`define GP_RST_PORT 7'h00
`define GP_RST_IPSEL 8'h00
`define GP_UNDEF_READ 8'h00
`define GP_BIT_EXPANSION_INTERRUPT_7_IN_EN 7
`define GP_PIN_TX0 0
`define GP_PIN_RX0 1
`define GP_PIN_CK0 2
`define GP_PIN_TX1 3
`define GP_PIN_RX1 4
`define GP_PIN_CK1 5
`define GP_PIN_EX7 6
`endif

// *** pkg/gpio_port_pkg.sv ***
// types shared by the seven-pin port
package gpio_port_pkg;
  // controls from one serial channel
  typedef struct packed {
    logic tx_en;
    logic tx_data;
    logic rx_en;
    logic clk_out_en;
    logic clk_out_data;
    logic clk_in_en;
  } serial_ctl_t;
  // pin levels handed to one serial channel
  typedef struct packed {
    logic rx_data;
    logic clk_in;
  } serial_in_t;
  // interrupt pin levels, active low
  typedef struct packed {
    logic external_interrupt_4_in;
    logic external_interrupt_5_in;
    logic expansion_interrupt_7_in;
  } irq_in_t;
  // register bus handshake state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
endpackage : gpio_port_pkg

// *** rtl/pin_sync.sv ***
// two-flop synchroniser for the pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // first stage feeds only the second; reset to the pulled-up idle level, so no false low follows reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** rtl/seven_bit_io_port.sv ***
// seven-pin general-purpose port with serial and interrupt sharing
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.svh"
module seven_bit_io_port #(
  parameter int PINS = `GP_PIN_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [`GP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  input wire gpio_port_pkg::serial_ctl_t serial0_ctl,
  input wire gpio_port_pkg::serial_ctl_t serial1_ctl,
  output gpio_port_pkg::serial_in_t serial0_in,
  output gpio_port_pkg::serial_in_t serial1_in,
  output gpio_port_pkg::irq_in_t irq_in
);

  // registers and bus state
  logic [PINS-1:0] dir_q;
  logic [PINS-1:0] latch_q;
  logic [PINS-1:0] odr_q;
  logic [7:0] ipsel_q;
  logic [PINS-1:0] view_q;
  logic [PINS-1:0] pin_sync_q;
  gpio_port_pkg::bus_state_t state_q;
  gpio_port_pkg::bus_state_t state_d;
  logic [31:0] readdata_d;

  // request present and accepted at this edge
  logic req;
  logic take;
  logic wr_take;
  logic [7:0] wbyte;
  assign req = avs_read | avs_write;
  assign take = req & (state_q == gpio_port_pkg::BUS_ACK);
  assign wr_take = take & avs_write & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // address decode, used for reads, writes and checks
  function automatic logic reg_hit(input logic [`GP_ADDR_W-1:0] a, input logic [15:0] idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction : reg_hit

  // pin synchroniser, only the checks look at the raw pins
  pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync_q)
  );

  // handshake: one wait cycle, then a single acknowledge cycle
  always_comb
  begin
    case (state_q)
      gpio_port_pkg::BUS_IDLE: state_d = req ? gpio_port_pkg::BUS_ACK : gpio_port_pkg::BUS_IDLE;
      gpio_port_pkg::BUS_ACK: state_d = gpio_port_pkg::BUS_IDLE;
      default: state_d = gpio_port_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= gpio_port_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      avs_waitrequest <= (state_d != gpio_port_pkg::BUS_ACK);
    end
  end

  // read mux, evaluated while the request waits
  always_comb
  begin
    readdata_d = 32'h0000_0000;
    if (reg_hit(avs_address, `GP_IDX_DIR))
      readdata_d[7:0] = `GP_UNDEF_READ;
    else if (reg_hit(avs_address, `GP_IDX_ODR))
      readdata_d[PINS-1:0] = odr_q;
    else if (reg_hit(avs_address, `GP_IDX_IPSEL))
      readdata_d[7:0] = ipsel_q;
    else if (reg_hit(avs_address, `GP_IDX_LATCH))
      readdata_d[PINS-1:0] = latch_q;
    else if (reg_hit(avs_address, `GP_IDX_VIEW))
      readdata_d[PINS-1:0] = view_q;
  end

  // read data stands with the acknowledge cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && state_q == gpio_port_pkg::BUS_IDLE)
      avs_readdata <= readdata_d;
  end

  // direction register, write-only, bit 7 not stored
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      dir_q <= `GP_RST_PORT;
    else if (hw_standby)
      dir_q <= `GP_RST_PORT;
    else if (wr_take && reg_hit(avs_address, `GP_IDX_DIR))
      dir_q <= wbyte[PINS-1:0];
  end

  // output latch
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      latch_q <= `GP_RST_PORT;
    else if (hw_standby)
      latch_q <= `GP_RST_PORT;
    else if (wr_take && reg_hit(avs_address, `GP_IDX_LATCH))
      latch_q <= wbyte[PINS-1:0];
  end

  // open-drain select
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      odr_q <= `GP_RST_PORT;
    else if (hw_standby)
      odr_q <= `GP_RST_PORT;
    else if (wr_take && reg_hit(avs_address, `GP_IDX_ODR))
      odr_q <= wbyte[PINS-1:0];
  end

  // interrupt pin select, all eight bits kept
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ipsel_q <= `GP_RST_IPSEL;
    else if (hw_standby)
      ipsel_q <= `GP_RST_IPSEL;
    else if (wr_take && reg_hit(avs_address, `GP_IDX_IPSEL))
      ipsel_q <= wbyte;
  end

  // pin view: latch for outputs, pins for inputs; frozen in software standby
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      view_q <= `GP_RST_PORT;
    else if (!sw_standby)
      view_q <= (dir_q & latch_q) | (~dir_q & pin_sync_q);
  end

  // alternate functions claiming each pin, fixed map with no mode input
  logic [PINS-1:0] alt_out_en;
  logic [PINS-1:0] alt_out_data;
  logic [PINS-1:0] alt_in_claim;
  always_comb
  begin
    alt_out_en = '0;
    alt_out_data = '0;
    alt_in_claim = '0;
    alt_out_en[`GP_PIN_TX0] = serial0_ctl.tx_en;
    alt_out_data[`GP_PIN_TX0] = serial0_ctl.tx_data;
    alt_in_claim[`GP_PIN_RX0] = serial0_ctl.rx_en;
    alt_out_en[`GP_PIN_CK0] = serial0_ctl.clk_out_en;
    alt_out_data[`GP_PIN_CK0] = serial0_ctl.clk_out_data;
    alt_in_claim[`GP_PIN_CK0] = serial0_ctl.clk_in_en;
    alt_out_en[`GP_PIN_TX1] = serial1_ctl.tx_en;
    alt_out_data[`GP_PIN_TX1] = serial1_ctl.tx_data;
    alt_in_claim[`GP_PIN_RX1] = serial1_ctl.rx_en;
    alt_out_en[`GP_PIN_CK1] = serial1_ctl.clk_out_en;
    alt_out_data[`GP_PIN_CK1] = serial1_ctl.clk_out_data;
    alt_in_claim[`GP_PIN_CK1] = serial1_ctl.clk_in_en;
    alt_in_claim[`GP_PIN_EX7] = ipsel_q[`GP_BIT_EXPANSION_INTERRUPT_7_IN_EN];
  end

  // per-pin driver: push-pull or open drain, registered onto the pad
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pin
      logic drive;
      logic data;
      assign drive = alt_out_en[gi] | (~alt_in_claim[gi] & dir_q[gi]);
      assign data = alt_out_en[gi] ? alt_out_data[gi] : latch_q[gi];
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi] <= 1'b0;
        end
        else
        begin
          pin_out[gi] <= data;
          pin_oe[gi] <= drive & (~odr_q[gi] | ~data);
        end
      end
    end
  endgenerate

  // synchronised levels handed to the serial and interrupt units
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      serial0_in <= '0;
      serial1_in <= '0;
      irq_in <= '1;
    end
    else
    begin
      serial0_in.rx_data <= pin_sync_q[`GP_PIN_RX0];
      serial0_in.clk_in <= pin_sync_q[`GP_PIN_CK0];
      serial1_in.rx_data <= pin_sync_q[`GP_PIN_RX1];
      serial1_in.clk_in <= pin_sync_q[`GP_PIN_CK1];
      irq_in.external_interrupt_4_in <= pin_sync_q[`GP_PIN_CK0];
      irq_in.external_interrupt_5_in <= pin_sync_q[`GP_PIN_CK1];
      irq_in.expansion_interrupt_7_in <= ~ipsel_q[`GP_BIT_EXPANSION_INTERRUPT_7_IN_EN] | pin_sync_q[`GP_PIN_EX7];
    end
  end

  // edges since reset, so pipeline checks skip the edges that still flush reset values
  logic [1:0] settle_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      settle_q <= 2'h0;
    else if (settle_q != 2'h3)
      settle_q <= settle_q + 2'h1;
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence seq_req_waiting;
    req && avs_waitrequest && state_q == gpio_port_pkg::BUS_IDLE;
  endsequence

  sequence seq_ack_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  chk_bus_ack:
  assert property (seq_req_waiting |=> seq_ack_once)
    else $error("bus request not acknowledged after one wait cycle");

  chk_dir_unreadable:
  assert property (avs_read && state_q == gpio_port_pkg::BUS_IDLE && reg_hit(avs_address, `GP_IDX_DIR)
    |=> avs_readdata == 32'h0000_0000)
    else $error("direction register read returned stored data");

  chk_latch_read:
  assert property (avs_read && state_q == gpio_port_pkg::BUS_IDLE && reg_hit(avs_address, `GP_IDX_LATCH)
    |=> avs_readdata == {25'h000_0000, $past(latch_q)})
    else $error("output latch read mismatch");

  chk_view_ro:
  assert property (wr_take && reg_hit(avs_address, `GP_IDX_VIEW) && !hw_standby
    |=> $stable(latch_q) && $stable(dir_q) && $stable(odr_q))
    else $error("write to pin view changed a register");

  chk_view_mix:
  assert property (settle_q != 2'h0 && !sw_standby
    |=> view_q == (($past(dir_q) & $past(latch_q)) | (~$past(dir_q) & $past(pin_sync_q))))
    else $error("pin view does not mix latch and pins by direction");

  chk_view_hold:
  assert property (sw_standby |=> $stable(view_q))
    else $error("pin view changed in software standby");

  chk_standby_clear:
  assert property (hw_standby |=> dir_q == 7'h00 && latch_q == 7'h00 && odr_q == 7'h00 && ipsel_q == 8'h00)
    else $error("hardware standby did not clear the port registers");

  chk_open_drain:
  assert property ((pin_oe & pin_out & $past(odr_q)) == 7'h00)
    else $error("open-drain pin driven high");

  chk_tx_open_drain:
  assert property (serial1_ctl.tx_en && serial1_ctl.tx_data && odr_q[`GP_PIN_TX1] |=> !pin_oe[`GP_PIN_TX1])
    else $error("serial transmit drove high in open-drain mode");

  chk_rx_claim:
  assert property (serial0_ctl.rx_en |=> !pin_oe[`GP_PIN_RX0])
    else $error("receive pin driven while receiver enabled");

  chk_exirq_claim:
  assert property (ipsel_q[`GP_BIT_EXPANSION_INTERRUPT_7_IN_EN] |=> !pin_oe[`GP_PIN_EX7])
    else $error("pin 6 driven while expansion interrupt selected");

  chk_plain_drive:
  assert property (!ipsel_q[`GP_BIT_EXPANSION_INTERRUPT_7_IN_EN] && !odr_q[`GP_PIN_EX7]
    |=> pin_oe[`GP_PIN_EX7] == $past(dir_q[`GP_PIN_EX7]) && pin_out[`GP_PIN_EX7] == $past(latch_q[`GP_PIN_EX7]))
    else $error("plain pin does not follow direction and latch");

  chk_sync_delay:
  assert property (settle_q == 2'h3 |-> serial0_in.rx_data == $past(pin_in[`GP_PIN_RX0], 3))
    else $error("receive level not three cycles behind pin");

  chk_irq_follow:
  assert property (settle_q == 2'h3 |-> irq_in.external_interrupt_4_in == $past(pin_in[`GP_PIN_CK0], 3))
    else $error("interrupt 4 level not three cycles behind pin");

  chk_exirq_idle:
  assert property (!ipsel_q[`GP_BIT_EXPANSION_INTERRUPT_7_IN_EN] |=> irq_in.expansion_interrupt_7_in)
    else $error("expansion interrupt active while pin 6 not selected");

endmodule : seven_bit_io_port
`default_nettype wire

// *** tb/pin_board.sv ***
// board model: pull-ups and external drivers on the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  output logic [6:0] pin_level
);
  // port drive wins, then an external driver, else the pull-up
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : pin_board
`default_nettype wire

// *** tb/seven_bit_io_port_bench.sv ***
// self-checking bench of the seven-pin port
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.svh"
module seven_bit_io_port_bench;
  typedef struct {logic [15:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic [17:0] avs_address = 18'h00000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:0] pin_in, pin_out, pin_oe;
  logic [6:0] ext_en = 7'h00;
  logic [6:0] ext_val = 7'h00;
  gpio_port_pkg::serial_ctl_t serial0_ctl = '0;
  gpio_port_pkg::serial_ctl_t serial1_ctl = '0;
  gpio_port_pkg::serial_in_t serial0_in, serial1_in;
  gpio_port_pkg::irq_in_t irq_in;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] rv;
  row_t rows[6] = '{'{`GP_IDX_ODR, 8'hFF, 8'h7F}, '{`GP_IDX_IPSEL, 8'hA5, 8'hA5},
    '{`GP_IDX_LATCH, 8'hD5, 8'h55}, '{`GP_IDX_DIR, 8'hFF, 8'h00},
    '{`GP_IDX_VIEW, 8'h00, 8'h55}, '{16'h0100, 8'hFF, 8'h00}};

  seven_bit_io_port u_dut (.ref_clk, .rst, .hw_standby, .sw_standby, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in,
    .pin_out, .pin_oe, .serial0_ctl, .serial1_ctl, .serial0_in, .serial1_in, .irq_in);
  pin_board u_board (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_level(pin_in));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, wd};
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rv = avs_readdata[7:0];
    if (!wr)
    begin
      check(avs_readdata[31:8], 32'h0, "upper lanes");
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      end_sim();
    end
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    check(rv, exp, what);
  endtask : rdchk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // overall hang guard
  initial
  begin
    tick(20000);
    miscompares++;
    end_sim();
  end

  // main sequence
  initial
  begin
    tick(4);
    rst <= 1'b0;
    tick(1);
    check(pin_oe, 7'h00, "oe after reset");
    rdchk(`GP_IDX_LATCH, 8'h00, "latch reset");
    rdchk(`GP_IDX_ODR, 8'h00, "odr reset");
    rdchk(`GP_IDX_IPSEL, 8'h00, "ipsel reset");
    rdchk(`GP_IDX_VIEW, 8'h7F, "view of pulled pins");
    $display("done: reset values");
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd);
      rdchk(rows[i].idx, rows[i].rd, "table row");
    end
    check(pin_oe, 7'h2A, "open drain oe");
    check(pin_out & pin_oe, 7'h00, "open drain low");
    $display("done: register table");
    hw_standby <= 1'b1;
    tick(1);
    hw_standby <= 1'b0;
    tick(2);
    check(pin_oe, 7'h00, "standby oe");
    rdchk(`GP_IDX_LATCH, 8'h00, "standby latch");
    rdchk(`GP_IDX_ODR, 8'h00, "standby odr");
    rdchk(`GP_IDX_IPSEL, 8'h00, "standby ipsel");
    $display("done: hardware standby");
    wr(`GP_IDX_DIR, 8'h0F);
    wr(`GP_IDX_LATCH, 8'h05);
    ext_en <= 7'h70;
    ext_val <= 7'h20;
    tick(4);
    check(pin_oe, 7'h0F, "push-pull oe");
    check(pin_out & 7'h0F, 7'h05, "push-pull data");
    rdchk(`GP_IDX_VIEW, 8'h25, "mixed view");
    sw_standby <= 1'b1;
    ext_val <= 7'h50;
    tick(4);
    rdchk(`GP_IDX_VIEW, 8'h25, "frozen view");
    sw_standby <= 1'b0;
    tick(4);
    rdchk(`GP_IDX_VIEW, 8'h55, "view resumes");
    $display("done: pin view");
    wr(`GP_IDX_ODR, 8'h01);
    tick(2);
    check(pin_oe, 7'h0E, "open drain high");
    wr(`GP_IDX_LATCH, 8'h04);
    tick(2);
    check(pin_oe, 7'h0F, "open drain low oe");
    check(pin_out[0], 1'b0, "open drain low data");
    avs_byteenable <= 4'h0;
    wr(`GP_IDX_LATCH, 8'hFF);
    avs_byteenable <= 4'hF;
    rdchk(`GP_IDX_LATCH, 8'h04, "lane off write");
    $display("done: open drain");
    serial0_ctl.rx_en <= 1'b1;
    ext_en <= 7'h72;
    ext_val <= 7'h02;
    tick(5);
    check(pin_oe[1], 1'b0, "receive pin oe");
    check(serial0_in.rx_data, 1'b1, "receive high");
    ext_val <= 7'h00;
    tick(4);
    check(serial0_in.rx_data, 1'b0, "receive low");
    serial1_ctl.tx_en <= 1'b1;
    serial1_ctl.tx_data <= 1'b1;
    tick(2);
    check(pin_oe[3], 1'b1, "transmit oe");
    check(pin_out[3], 1'b1, "transmit data");
    wr(`GP_IDX_ODR, 8'h09);
    tick(2);
    check(pin_oe[3], 1'b0, "transmit open drain");
    $display("done: serial sharing");
    wr(`GP_IDX_DIR, 8'h4F);
    wr(`GP_IDX_IPSEL, 8'h80);
    ext_en <= 7'h40;
    ext_val <= 7'h00;
    tick(4);
    check(pin_oe[6], 1'b0, "irq pin oe");
    check(irq_in.expansion_interrupt_7_in, 1'b0, "irq level");
    wr(`GP_IDX_IPSEL, 8'h00);
    tick(2);
    check(pin_oe[6], 1'b1, "pin6 output");
    $display("done: expansion interrupt");
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    check(pin_oe, 7'h00, "second reset oe");
    rdchk(`GP_IDX_ODR, 8'h00, "second reset odr");
    $display("done: second reset");
    end_sim();
  end
endmodule : seven_bit_io_port_bench
`default_nettype wire
